// File: verilog/adcseq_pkg.sv
// Constants, types and state layout of the converter sequencer
// Operation
// - Result is 10 bits over two bytes, right aligned unless left adjust set.
// - Low byte read locks both result bytes until high byte read.
// - Result finished while locked is dropped, completion flag still set.
// - Writing start begins conversion; start bit high while busy, cleared at end.
// - Channel changes during a conversion apply only after it finishes.
// - Auto trigger rising edge resets prescaler and starts conversion.
// - Trigger edges during conversion ignored; a level held high restarts nothing.
// - Event flags set even when masked; software clears them before next trigger.
// - Completion flag as source gives free running; first start by software.
// - Software start works with auto trigger; start bit high in any conversion.
// - Prescaler counts from enable, divides by select, held reset while disabled.
// - Reference and channel selections act only while converter is enabled.
// - Software conversion begins at next converter clock rising edge.
// - Normal conversion 13 converter cycles, first after enable 25 cycles.
// - Sample and hold at 1.5 cycles normally, 13.5 cycles for first.
// - At completion write result, set flag, clear start bit in single mode.
// - Auto triggered: sample 2 cycles after edge, 3 sync clocks, 13.5 total.
// - Free running restarts right after each completion, start bit stays high.
// - Channel codes select any input pin, ground or the bandgap voltage.
// - Reference bits switch analog supply or internal 1.1V reference onto pin.
// - Selections track temporary copy until start, held, reopen in last cycle.
// - Enabled single mode with interrupt on: halted sleep starts a conversion.
`default_nettype none
package adcseq_pkg;

  // =========================================================================
  // Timing, in converter clock cycles; trigger synchroniser depth in CPU clocks
  localparam logic [4:0] ADCSEQ_NORM_END     = 5'h0d;
  localparam logic [4:0] ADCSEQ_FIRST_END    = 5'h19;
  localparam logic [4:0] ADCSEQ_NORM_SAMPLE  = 5'h01;
  localparam logic [4:0] ADCSEQ_FIRST_SAMPLE = 5'h0d;
  localparam logic [4:0] ADCSEQ_AUTO_SAMPLE  = 5'h02;
  localparam logic [4:0] ADCSEQ_AUTO_END     = 5'h0d;
  localparam int         ADCSEQ_TRIG_SYNC    = 3;

  // =========================================================================
  // Encodings
  localparam logic [2:0] ADCSEQ_SRC_COMPLETE = 3'h0;
  localparam logic [3:0] ADCSEQ_CH_BANDGAP   = 4'he;
  localparam logic [3:0] ADCSEQ_CH_GROUND    = 4'hf;
  localparam logic [1:0] ADCSEQ_REF_PIN      = 2'h0;
  localparam logic [1:0] ADCSEQ_REF_AVCC     = 2'h1;
  localparam logic [1:0] ADCSEQ_REF_INT11    = 2'h3;
  localparam logic [9:0] ADCSEQ_TRIAL_MSB    = 10'h200;
  localparam logic [3:0] ADCSEQ_BITS         = 4'ha;

  // =========================================================================
  // Types
  typedef enum logic [1:0] {
    ADCSEQ_IDLE = 2'b00,
    ADCSEQ_CONV = 2'b01
  } adcseq_state_t;

  typedef struct packed {
    logic       converter_enable;
    logic       converter_power_reduction;
    logic       auto_trigger_enable;
    logic [2:0] trigger_source_select;
    logic [2:0] prescaler_select;
    logic       left_adjust_select;
    logic [1:0] reference_select;
    logic [3:0] channel_select;
    logic       complete_irq_enable;
  } adcseq_cfg_t;

  typedef struct packed {
    logic       analog_enable;
    logic       sample_hold;
    logic [9:0] dac_trial;
    logic [3:0] channel;
    logic       ref_avcc_switch;
    logic       ref_int11_switch;
  } adcseq_analog_t;

  typedef struct packed {
    adcseq_state_t  st;
    logic [7:0]     presc;
    logic [4:0]     cyc;
    logic           first;
    logic           auto_conv;
    logic           sw_pending;
    logic [3:0]     bits_left;
    logic           sampled;
    logic [9:0]     result;
    logic           lock;
    logic           flag;
    logic           start_bit;
    logic [ADCSEQ_TRIG_SYNC-1:0] trig_pipe;
    logic           trig_prev;
    logic [7:0]     low_byte;
    logic [7:0]     high_byte;
    adcseq_analog_t ana;
  } adcseq_regs_t;

endpackage
`default_nettype wire

// File: verilog/adcseq_top.sv
// Conversion sequencer: prescaler, start control, timing, SAR steps, result lock
`timescale 1ns/100ps
`default_nettype none
module adcseq_top (
  input  wire logic                   clock,            // 20 MHz CPU clock
  input  wire logic                   rst,              // Async reset, high
  input  wire adcseq_pkg::adcseq_cfg_t cfg,             // Control settings
  input  wire logic                   start_write,      // Software writes start one
  input  wire logic                   flag_clear,       // Software clears flag
  input  wire logic                   low_read,         // Low result byte read
  input  wire logic                   high_read,        // High result byte read
  input  wire logic                   sleep_halt,       // CPU halted in quiet sleep
  input  wire logic [7:0]             trigger_events,   // On-chip event flags
  input  wire logic                   comparator_high,  // Input at or above trial
  output logic [7:0]                  result_low_byte,  // Low result byte
  output logic [7:0]                  result_high_byte, // High result byte
  output logic                        start_conversion_bit, // Busy / start bit
  output logic                        conversion_complete_flag, // Completion flag
  output adcseq_pkg::adcseq_analog_t  analog            // Analog front end controls
);
  import adcseq_pkg::*;

  // ==========================================================================
  // State
  adcseq_regs_t s;
  adcseq_regs_t next_s;

  logic       en;
  logic [7:0] div;
  logic       rise;
  logic       fall;
  logic       freerun;
  logic       trig_raw;
  logic       trig_edge;
  logic       conv_start;
  logic       sample_now;
  logic       end_now;
  logic [4:0] end_cyc;
  logic [4:0] cyc_after;
  logic       step_now;
  logic [9:0] trial;
  logic       sel_open;

  // ==========================================================================
  // Combinational next state
  always_comb begin
    next_s = s;
    next_s.ana.sample_hold = 1'b0;

    en = cfg.converter_enable & ~cfg.converter_power_reduction;
    if (cfg.prescaler_select == 3'h0) begin
      div = 8'h02;
    end else begin
      div = 8'h01 << cfg.prescaler_select;
    end
    // A count left above a newly chosen smaller ratio ticks at once rather than wrapping
    rise = en & (s.presc >= div - 8'h01);
    fall = en & (s.presc == (div >> 1) - 8'h01);
    freerun = cfg.auto_trigger_enable & (cfg.trigger_source_select == ADCSEQ_SRC_COMPLETE);

    // Event flags are kept by their owners whether masked or not, so an
    // uncleared flag simply never makes a second rising edge here.
    if (cfg.trigger_source_select == ADCSEQ_SRC_COMPLETE) begin
      trig_raw = 1'b0;
    end else begin
      trig_raw = trigger_events[cfg.trigger_source_select];
    end
    next_s.trig_pipe = {s.trig_pipe[ADCSEQ_TRIG_SYNC-2:0], trig_raw};
    next_s.trig_prev = s.trig_pipe[ADCSEQ_TRIG_SYNC-1];
    trig_edge = s.trig_pipe[ADCSEQ_TRIG_SYNC-1] & ~s.trig_prev;

    // Prescaler runs only while enabled
    if (!en) begin
      next_s.presc = 8'h00;
    end else if (rise) begin
      next_s.presc = 8'h00;
    end else begin
      next_s.presc = s.presc + 8'h01;
    end

    // Software and sleep requests
    if (en && start_write) begin
      next_s.start_bit = 1'b1;
      if (s.st == ADCSEQ_IDLE) begin
        next_s.sw_pending = 1'b1;
      end
    end
    if (en && sleep_halt && !cfg.auto_trigger_enable && cfg.complete_irq_enable &&
        s.st == ADCSEQ_IDLE) begin
      next_s.start_bit = 1'b1;
      next_s.sw_pending = 1'b1;
    end

    // Result read lock
    if (low_read) begin
      next_s.lock = 1'b1;
    end
    if (high_read) begin
      next_s.lock = 1'b0;
    end

    conv_start = 1'b0;
    sample_now = 1'b0;
    end_now = 1'b0;
    step_now = 1'b0;
    trial = s.ana.dac_trial;
    cyc_after = s.cyc + 5'h01;
    end_cyc = s.first ? ADCSEQ_FIRST_END : ADCSEQ_NORM_END;
    sel_open = 1'b1;

    case (s.st)
      ADCSEQ_IDLE: begin
        if (en && trig_edge && cfg.auto_trigger_enable && !freerun) begin
          next_s.presc = 8'h00;
          next_s.auto_conv = ~s.first;
          next_s.start_bit = 1'b1;
          next_s.sw_pending = 1'b0;
          conv_start = 1'b1;
        end else if (en && s.sw_pending && rise) begin
          next_s.auto_conv = 1'b0;
          next_s.sw_pending = 1'b0;
          conv_start = 1'b1;
        end
      end
      ADCSEQ_CONV: begin
        sel_open = 1'b0;
        if (rise) begin
          next_s.cyc = cyc_after;
        end
        if (s.auto_conv) begin
          sample_now = rise & (cyc_after == ADCSEQ_AUTO_SAMPLE);
          end_now = fall & (s.cyc == ADCSEQ_AUTO_END);
          sel_open = (s.cyc == ADCSEQ_AUTO_END);
        end else if (s.first) begin
          sample_now = fall & (s.cyc == ADCSEQ_FIRST_SAMPLE);
          end_now = rise & (cyc_after == ADCSEQ_FIRST_END);
          sel_open = (cyc_after == end_cyc);
        end else begin
          sample_now = fall & (s.cyc == ADCSEQ_NORM_SAMPLE);
          end_now = rise & (cyc_after == ADCSEQ_NORM_END);
          sel_open = (cyc_after == end_cyc);
        end
        step_now = rise & s.sampled & (s.bits_left != 4'h0) & ~sample_now;
      end
      default: begin
        next_s.st = ADCSEQ_IDLE;
      end
    endcase

    // One successive approximation decision per converter clock
    if (step_now) begin
      if (!comparator_high) begin
        trial[s.bits_left - 4'h1] = 1'b0;
      end
      if (s.bits_left > 4'h1) begin
        trial[s.bits_left - 4'h2] = 1'b1;
      end
      next_s.bits_left = s.bits_left - 4'h1;
      next_s.ana.dac_trial = trial;
    end

    if (sample_now) begin
      next_s.ana.sample_hold = 1'b1;
      next_s.sampled = 1'b1;
      next_s.bits_left = ADCSEQ_BITS;
      next_s.ana.dac_trial = ADCSEQ_TRIAL_MSB;
    end

    if (end_now) begin
      if (!s.lock) begin
        next_s.result = trial;
      end
      next_s.first = 1'b0;
      if (freerun) begin
        conv_start = 1'b1;
        next_s.auto_conv = 1'b0;
      end else begin
        next_s.st = ADCSEQ_IDLE;
        next_s.start_bit = 1'b0;
      end
    end

    if (conv_start) begin
      next_s.st = ADCSEQ_CONV;
      next_s.cyc = 5'h00;
      next_s.sampled = 1'b0;
      next_s.bits_left = 4'h0;
    end

    // A finishing conversion beats a clear in the same cycle
    next_s.flag = (s.flag & ~flag_clear) | end_now;

    // Disabling aborts and re-arms the long first conversion
    if (!en) begin
      next_s.st = ADCSEQ_IDLE;
      next_s.start_bit = 1'b0;
      next_s.sw_pending = 1'b0;
      next_s.first = 1'b1;
      next_s.sampled = 1'b0;
    end

    // Selections follow the temporary copy only while open and enabled
    next_s.ana.analog_enable = en;
    if (en && sel_open) begin
      next_s.ana.channel = cfg.channel_select;
      next_s.ana.ref_avcc_switch = (cfg.reference_select == ADCSEQ_REF_AVCC);
      next_s.ana.ref_int11_switch = (cfg.reference_select == ADCSEQ_REF_INT11);
    end else if (!en) begin
      next_s.ana.ref_avcc_switch = 1'b0;
      next_s.ana.ref_int11_switch = 1'b0;
    end

    // Bytes follow the stored result; the stored result is what the lock freezes
    if (cfg.left_adjust_select) begin
      next_s.high_byte = s.result[9:2];
      next_s.low_byte = {s.result[1:0], 6'h00};
    end else begin
      next_s.high_byte = {6'h00, s.result[9:8]};
      next_s.low_byte = s.result[7:0];
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.st <= ADCSEQ_IDLE;
      s.first <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs straight from state
  assign result_low_byte = s.low_byte;
  assign result_high_byte = s.high_byte;
  assign start_conversion_bit = s.start_bit;
  assign conversion_complete_flag = s.flag;
  assign analog = s.ana;

endmodule
`default_nettype wire

// File: dv/adcseq_chk.sv
// Port checker for the conversion sequencer, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module adcseq_chk (
  input wire logic                       clock,                    // CPU clock
  input wire logic                       rst,                      // Async reset
  input wire adcseq_pkg::adcseq_cfg_t    cfg,                      // Settings
  input wire logic                       start_write,              // Start request
  input wire logic                       flag_clear,               // Flag clear
  input wire logic                       low_read,                 // Low byte read
  input wire logic                       high_read,                // High byte read
  input wire logic [7:0]                 result_low_byte,          // Low byte
  input wire logic [7:0]                 result_high_byte,         // High byte
  input wire logic                       start_conversion_bit,     // Busy bit
  input wire logic                       conversion_complete_flag, // Done flag
  input wire adcseq_pkg::adcseq_analog_t analog                    // Analog controls
);
  import adcseq_pkg::*;
  // ==========================
  // Helpers
  wire en = cfg.converter_enable & ~cfg.converter_power_reduction;
  logic lk;
  logic lk_d;
  // Lock is judged one cycle late so a result already in flight may still land
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lk <= 1'b0;
      lk_d <= 1'b0;
    end else begin
      lk <= high_read ? 1'b0 : (low_read | lk);
      lk_d <= lk;
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // ==========================
  // Assertions
  start_rise_a: assert property (start_write && en && !start_conversion_bit ##1 en
    |-> start_conversion_bit) else $error("start bit did not rise");
  flag_on_end_a: assert property ($fell(start_conversion_bit) && en && $past(en)
    |-> ##[0:2] conversion_complete_flag) else $error("no flag at end");
  flag_sticky_a: assert property (conversion_complete_flag && !flag_clear
    |=> conversion_complete_flag) else $error("flag dropped");
  lock_hold_a: assert property (lk && lk_d && $stable(cfg.left_adjust_select)
    |=> $stable(result_low_byte) && $stable(result_high_byte)) else $error("locked bytes moved");
  disabled_quiet_a: assert property (!en [*2] |-> !start_conversion_bit
    && !analog.ref_avcc_switch && !analog.ref_int11_switch) else $error("active while off");
  sample_pulse_a: assert property (analog.sample_hold |-> start_conversion_bit
    ##1 !analog.sample_hold) else $error("bad sample pulse");
  right_align_a: assert property (!cfg.left_adjust_select [*2]
    |-> result_high_byte[7:2] == 6'h0) else $error("right align broken");
  left_align_a: assert property (cfg.left_adjust_select [*2]
    |-> result_low_byte[5:0] == 6'h0) else $error("left align broken");
endmodule
bind adcseq_top adcseq_chk u_chk (.clock, .rst, .cfg, .start_write, .flag_clear, .low_read,
  .high_read, .result_low_byte, .result_high_byte, .start_conversion_bit,
  .conversion_complete_flag, .analog);
`default_nettype wire

// File: dv/adcseq_afe.sv
// Behavioural analog front end: sample-and-hold and comparator
`timescale 1ns/100ps
`default_nettype none
module adcseq_afe (
  input  wire logic                       clock,          // CPU clock
  input  wire logic                       rst,            // Async reset
  input  wire adcseq_pkg::adcseq_analog_t analog,         // Sequencer controls
  input  wire logic [9:0]                 vin,            // Input level as a code
  output logic                            comparator_high // Held input at or above trial
);
  import adcseq_pkg::*;
  // ==========================
  // Hold and compare
  logic [9:0] held;
  logic       noise;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held <= 10'h0;
      noise <= 1'b0;
    end else begin
      noise <= ~noise;
      if (analog.sample_hold) held <= vin;
    end
  end
  // Unpowered comparator gives no usable answer, so it toggles.
  // The hold capacitor follows the input while the sample pulse stands.
  assign comparator_high = analog.analog_enable ?
    ((analog.sample_hold ? vin : held) >= analog.dac_trial) : noise;
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import adcseq_pkg::*;
  // ==========================
  // Signals and instances
  logic           clock = 1'b0;
  logic           rst = 1'b1;
  adcseq_cfg_t    cfg = '0;
  logic           start_write = 1'b0, flag_clear = 1'b0, sleep_halt = 1'b0;
  logic           low_read = 1'b0, high_read = 1'b0;
  logic [7:0]     trigger_events = 8'h0;
  logic [9:0]     vin = 10'h0;
  logic [9:0]     v;
  logic [7:0]     lo, hi;
  logic           scb, flag, comparator_high;
  adcseq_analog_t analog;
  logic [15:0]    seed = 16'h21;
  int             errors = 0, cmp_count = 0, div = 2, n;
  always #25 clock = ~clock;
  adcseq_top u_dut (.clock, .rst, .cfg, .start_write, .flag_clear, .low_read, .high_read,
    .sleep_halt, .trigger_events, .comparator_high, .result_low_byte(lo),
    .result_high_byte(hi), .start_conversion_bit(scb), .conversion_complete_flag(flag), .analog);
  adcseq_afe u_afe (.clock, .rst, .analog, .vin, .comparator_high);
  // ==========================
  // Helpers
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] exp_bytes(logic [9:0] x, logic la);
    return la ? {x, 6'h0} : {6'h0, x};
  endfunction
  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_t(int got, int lo_b, int hi_b);
    cmp_count++;
    if (got < lo_b || got > hi_b) begin
      errors++;
      $display("wrong value at %0t: conversion took %0d cycles", $time, got);
    end
  endtask
  // Pulse mask order: sleep, start, clear, low read, high read
  task automatic go(logic [4:0] m);
    {sleep_halt, start_write, flag_clear, low_read, high_read} <= m;
    @(posedge clock);
    {sleep_halt, start_write, flag_clear, low_read, high_read} <= 5'h0;
  endtask
  task automatic wait_flag();
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (flag !== 1'b1 && n < 4000);
    if (flag !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: completion flag never rose", $time);
    end
  endtask
  task automatic conv(logic [9:0] x, int ncyc, logic [15:0] e, logic [4:0] m);
    vin <= x;
    go(m);
    wait_flag();
    chk_t(n, ncyc * div, ncyc * div + div + 6);
    repeat (3) @(negedge clock);
    chk({hi, lo}, e, "bytes");
    @(posedge clock);
  endtask
  // ==========================
  // Scenarios
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    cfg.reference_select <= ADCSEQ_REF_INT11;
    cfg.channel_select <= 4'h2;
    cfg.prescaler_select <= 3'h1;
    cfg.converter_enable <= 1'b1;
    @(posedge clock);
    conv(10'h2a5, 25, 16'h02a5, 5'h0c);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : seed[9:0];
      cfg.prescaler_select <= 3'(i);
      cfg.left_adjust_select <= i[0];
      div = (i == 0) ? 2 : (1 << i);
      conv(v, 13, exp_bytes(v, i[0]), 5'h0c);
    end
    cfg.prescaler_select <= 3'h1;
    cfg.left_adjust_select <= 1'b0;
    div = 2;
    go(5'h0c);
    repeat (4) @(posedge clock);
    cfg.channel_select <= 4'h5;
    repeat (4) @(negedge clock);
    chk(16'({analog.channel, analog.ref_avcc_switch, analog.ref_int11_switch}), 16'h9, "mux");
    wait_flag();
    repeat (2) @(negedge clock);
    chk(16'(analog.channel), 16'h5, "mux");
    @(posedge clock);
    conv(10'h155, 13, 16'h0155, 5'h0c);
    go(5'h02);
    @(posedge clock);
    conv(10'h0aa, 13, 16'h0155, 5'h0c);
    go(5'h01);
    @(posedge clock);
    conv(10'h0aa, 13, 16'h00aa, 5'h0c);
    cfg.auto_trigger_enable <= 1'b1;
    cfg.trigger_source_select <= ADCSEQ_SRC_COMPLETE;
    conv(10'h301, 13, 16'h0301, 5'h0c);
    @(negedge clock);
    chk(16'(scb), 16'h1, "run");
    @(posedge clock);
    go(5'h04);
    wait_flag();
    chk_t(n, 1, 30);
    @(posedge clock);
    cfg.converter_enable <= 1'b0;
    cfg.trigger_source_select <= 3'h3;
    @(posedge clock);
    cfg.converter_enable <= 1'b1;
    trigger_events <= 8'h08;
    conv(10'h123, 25, 16'h0123, 5'h04);
    repeat (60) @(posedge clock);
    @(negedge clock);
    chk(16'(scb), 16'h0, "retrigger");
    @(posedge clock);
    conv(10'h3c0, 13, 16'h03c0, 5'h0c);
    trigger_events <= 8'h00;
    repeat (6) @(posedge clock);
    trigger_events <= 8'h08;
    conv(10'h0f0, 13, 16'h00f0, 5'h04);
    cfg.auto_trigger_enable <= 1'b0;
    cfg.complete_irq_enable <= 1'b1;
    conv(10'h2c3, 13, 16'h02c3, 5'h14);
    cfg.converter_power_reduction <= 1'b1;
    @(posedge clock);
    go(5'h0c);
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk(16'(scb), 16'h0, "off");
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
